// ==== verilog/srvsl_pkg.sv ====
/*
 * Constants, register map and filter, phase and loop state types of the servo speed loop with vector rotator.
 * Assumes a single 20 MHz clock, an APB master with 32-bit data and a resolver converter word on pins.
 */
package srvsl_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int OBS_PERIOD_US = 100;
	localparam int OBS_CYCLES = OBS_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int SAMPLE_PERIOD_US = 300;
	localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int CARRIER_BASE_HZ = 5000;
	localparam int CARRIER_FAST_HZ = 10000;
	localparam logic [11:0] CARRIER_HALF_BASE = 12'(CLK_HZ / (2 * CARRIER_BASE_HZ));
	localparam logic [11:0] CARRIER_HALF_FAST = 12'(CLK_HZ / (2 * CARRIER_FAST_HZ));
	localparam int MOD_SPAN = 65536;
	localparam logic [15:0] SLOPE_BASE = 16'(MOD_SPAN / int'(CARRIER_HALF_BASE));
	localparam logic [15:0] SLOPE_FAST = 16'(MOD_SPAN / int'(CARRIER_HALF_FAST));
	// register byte addresses
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_SPEED_REF = 12'h004;
	localparam logic [11:0] REG_FILT_FREQ = 12'h008;
	localparam logic [11:0] REG_PROP_GAIN = 12'h00c;
	localparam logic [11:0] REG_INT_GAIN = 12'h010;
	localparam logic [11:0] REG_SPEED_FB = 12'h014;
	localparam logic [11:0] REG_TORQUE = 12'h018;
	localparam logic [11:0] REG_POSITION = 12'h01c;
	localparam logic [11:0] REG_STATUS = 12'h020;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_FAST_BIT = 1;
	localparam int STATUS_SAT_BIT = 0;
	localparam int STATUS_BYPASS_BIT = 1;
	localparam int STATUS_RUN_BIT = 2;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [15:0] PROP_GAIN_RESET = 16'h0050;
	localparam logic [15:0] INT_GAIN_RESET = 16'h0014;
	localparam logic [7:0] FILT_FREQ_RESET = 8'h00;
	localparam logic [7:0] FILT_FREQ_MAX = 8'h64;
	localparam int FILT_FREQ_DIV = 200;
	localparam int SPEED_SCALE = 12;
	localparam logic signed [31:0] DAMP2_Q16 = 32'sh0001_69fb;
	localparam logic signed [31:0] ONE_Q16 = 32'sh0001_0000;
	localparam logic signed [31:0] TWO_Q16 = 32'sh0002_0000;
	localparam logic signed [15:0] OBS_ERR_LIMIT = 16'sh0400;
	localparam logic [15:0] PHASE_120 = 16'h5555;
	localparam logic [15:0] PHASE_90 = 16'h4000;

	typedef struct packed {
		logic signed [31:0] x1;
		logic signed [31:0] y1;
		logic signed [31:0] y2;
	} srvsl_filt_state_type;

	typedef struct packed {
		logic signed [15:0] u;
		logic signed [15:0] v;
		logic signed [15:0] w;
	} srvsl_phase_refs_type;

	typedef enum logic [3:0] {
		ST_WAIT = 4'b0001,
		ST_FILT = 4'b0010,
		ST_PI = 4'b0100,
		ST_ROT = 4'b1000
	} srvsl_loop_state_type;
endpackage : srvsl_pkg

// ==== verilog/srvsl_speed_loop.sv ====
/*
 * Speed loop of a servo drive: observer, filtered PI regulator, vector rotator and triangular-carrier PWM.
 * Assumes an APB master on clk, a resolver converter word and two modulating words arriving asynchronously on pins.
 */
`timescale 1ns/100ps
module srvsl_speed_loop
	import srvsl_pkg::*;
#(
	parameter int SAMPLE_CYC = SAMPLE_CYCLES,
	parameter int OBS_CYC = OBS_CYCLES,
	parameter int KP_SHIFT = 6,
	parameter int KI_SHIFT = 10,
	parameter int OBS_TQ_SHIFT = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// resolver converter and current controller modulation
	input wire logic [15:0] shaftPosition,
	input wire logic signed [15:0] modulationU,
	input wire logic signed [15:0] modulationV,
	// dac references
	output srvsl_phase_refs_type phaseCurrentRefs,
	output logic dacStrobe,
	// inverter gates
	output logic [2:0] gateHigh,
	output logic [2:0] gateLow
);

	function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
		if (v > 48'sh7fff)
			return 16'sh7fff;
		else if (v < -48'sh8000)
			return -16'sh8000;
		else
			return v[15:0];
	endfunction : sat16

	// ln(1/(1-x)) by its power series, x = setting/200 never above one half
	function automatic logic signed [31:0] lnInvQ16(input logic [7:0] setting);
		logic [63:0] x;
		logic [63:0] term;
		logic [63:0] sum;
		x = ({40'h0, setting, 16'h0}) / 64'(FILT_FREQ_DIV);
		term = x;
		sum = 64'h0;
		for (int k = 1; k <= 14; k++) begin
			sum = sum + term / 64'(k);
			term = (term * x) >> 16;
		end
		return 32'(sum);
	endfunction : lnInvQ16

	// y[n] = b x[n-1] - a1 y[n-1] - a2 y[n-2]
	function automatic srvsl_filt_state_type filterStep(input srvsl_filt_state_type s,
			input logic signed [31:0] x, input logic signed [31:0] b,
			input logic signed [31:0] a1, input logic signed [31:0] a2);
		srvsl_filt_state_type r;
		logic signed [63:0] acc;
		acc = 64'(b) * 64'(s.x1) - 64'(a1) * 64'(s.y1) - 64'(a2) * 64'(s.y2);
		r.x1 = x;
		r.y1 = 32'(acc >>> 16);
		r.y2 = s.y1;
		return r;
	endfunction : filterStep

	// parabolic sine with one refinement step, angle full turn = 65536
	function automatic logic signed [15:0] sinQ15(input logic [15:0] angle);
		logic signed [31:0] x;
		logic signed [31:0] ax;
		logic signed [31:0] y;
		logic signed [31:0] ay;
		logic signed [31:0] yy;
		x = 32'($signed(angle));
		ax = (x < 0) ? -x : x;
		y = (x * (32'sh8000 - ax)) >>> 13;
		ay = (y < 0) ? -y : y;
		yy = (y * ay) >>> 15;
		y = y + ((32'sh1ccd * (yy - y)) >>> 15);
		return sat16(48'(y));
	endfunction : sinQ15

	function automatic logic signed [15:0] cosQ15(input logic [15:0] angle);
		return sinQ15(angle + PHASE_90);
	endfunction : cosQ15

	function automatic logic signed [15:0] slopeLimit(input logic signed [15:0] cur,
			input logic signed [15:0] target, input logic [15:0] step);
		logic signed [17:0] d;
		d = 18'(target) - 18'(cur);
		if (d > 18'($signed({2'b00, step})))
			return 16'(18'(cur) + 18'($signed({2'b00, step})));
		else if (d < -18'($signed({2'b00, step})))
			return 16'(18'(cur) - 18'($signed({2'b00, step})));
		else
			return target;
	endfunction : slopeLimit

	// pin synchroniser: three stages, a change is taken once stages two and three agree
	logic [47:0] pinSync1;
	logic [47:0] pinSync2;
	logic [47:0] pinSync3;
	logic [47:0] pinStable;

	always_ff @(posedge clk) begin
		if (srst) begin
			pinSync1 <= 48'h0;
			pinSync2 <= 48'h0;
			pinSync3 <= 48'h0;
			pinStable <= 48'h0;
		end else begin
			pinSync1 <= {shaftPosition, modulationU, modulationV};
			pinSync2 <= pinSync1;
			pinSync3 <= pinSync2;
			if (pinSync2 == pinSync3)
				pinStable <= pinSync3;
		end
	end

	logic [15:0] position;
	logic signed [15:0] modU;
	logic signed [15:0] modV;
	assign position = pinStable[47:32];
	assign modU = pinStable[31:16];
	assign modV = pinStable[15:0];

	// register file
	logic [1:0] ctrl;
	logic signed [15:0] speedRef;
	logic [7:0] filtSetting;
	logic [15:0] propGain;
	logic [15:0] intGain;
	logic [1:0] next_ctrl;
	logic signed [15:0] next_speedRef;
	logic [7:0] next_filtSetting;
	logic [15:0] next_propGain;
	logic [15:0] next_intGain;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic signed [15:0] speedFb;
	logic signed [15:0] torque;
	logic saturated;
	logic apbWrite;
	logic mapped;

	always_comb begin
		next_ctrl = ctrl;
		next_speedRef = speedRef;
		next_filtSetting = filtSetting;
		next_propGain = propGain;
		next_intGain = intGain;
		next_prdata = prdata;
		next_pslverr = pslverr;
		// one wait state, so every answer comes from a register
		next_pready = psel & penable & ~pready;
		mapped = (paddr[1:0] == 2'h0) && (paddr <= REG_STATUS);
		apbWrite = psel & penable & pready & pwrite & mapped;
		if (next_pready) begin
			next_pslverr = ~mapped;
			case (paddr)
				REG_CTRL: next_prdata = {30'h0, ctrl};
				REG_SPEED_REF: next_prdata = 32'($signed(speedRef));
				REG_FILT_FREQ: next_prdata = {24'h0, filtSetting};
				REG_PROP_GAIN: next_prdata = {16'h0, propGain};
				REG_INT_GAIN: next_prdata = {16'h0, intGain};
				REG_SPEED_FB: next_prdata = 32'($signed(speedFb));
				REG_TORQUE: next_prdata = 32'($signed(torque));
				REG_POSITION: next_prdata = {16'h0, position};
				REG_STATUS: next_prdata = {29'h0, ctrl[CTRL_RUN_BIT], filtSetting == 8'h00, saturated};
				default: next_prdata = 32'h0;
			endcase
		end
		if (apbWrite) begin
			case (paddr)
				REG_CTRL: next_ctrl = pwdata[1:0];
				REG_SPEED_REF: next_speedRef = pwdata[15:0];
				// out-of-range settings are held at the top of the range
				REG_FILT_FREQ: next_filtSetting = (pwdata > 32'(FILT_FREQ_MAX)) ? FILT_FREQ_MAX : pwdata[7:0];
				REG_PROP_GAIN: next_propGain = pwdata[15:0];
				REG_INT_GAIN: next_intGain = pwdata[15:0];
				default: next_ctrl = ctrl;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl <= CTRL_RESET;
			speedRef <= 16'sh0000;
			filtSetting <= FILT_FREQ_RESET;
			propGain <= PROP_GAIN_RESET;
			intGain <= INT_GAIN_RESET;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			speedRef <= next_speedRef;
			filtSetting <= next_filtSetting;
			propGain <= next_propGain;
			intGain <= next_intGain;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// observer: position estimate, speed and acceleration; nonlinear through the clamped error
	logic [23:0] posEst;
	logic signed [31:0] obsSpeed;
	logic signed [31:0] obsAccel;
	logic [15:0] obsTimer;
	logic [23:0] next_posEst;
	logic signed [31:0] next_obsSpeed;
	logic signed [31:0] next_obsAccel;
	logic [15:0] next_obsTimer;
	logic signed [15:0] next_speedFb;
	logic signed [15:0] posErr;
	logic signed [31:0] errClamped;

	always_comb begin
		next_posEst = posEst;
		next_obsSpeed = obsSpeed;
		next_obsAccel = obsAccel;
		next_obsTimer = obsTimer + 16'h0001;
		posErr = $signed(position - posEst[23:8]);
		if (posErr > OBS_ERR_LIMIT)
			errClamped = 32'(OBS_ERR_LIMIT);
		else if (posErr < -OBS_ERR_LIMIT)
			errClamped = -32'(OBS_ERR_LIMIT);
		else
			errClamped = 32'(posErr);
		if (obsTimer == 16'(OBS_CYC - 1)) begin
			next_obsTimer = 16'h0000;
			next_posEst = posEst + obsSpeed[23:0] + 24'(errClamped <<< 7);
			next_obsSpeed = obsSpeed + (errClamped <<< 4) + obsAccel + (32'(torque) >>> OBS_TQ_SHIFT);
			next_obsAccel = obsAccel + errClamped;
		end
		// speed in counts per observer period, scaled to 0.656 x poles x rpm
		next_speedFb = sat16(48'((64'(obsSpeed) * 64'(SPEED_SCALE)) >>> 8));
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			posEst <= 24'h0;
			obsSpeed <= 32'sh0;
			obsAccel <= 32'sh0;
			obsTimer <= 16'h0;
			speedFb <= 16'sh0;
		end else begin
			posEst <= next_posEst;
			obsSpeed <= next_obsSpeed;
			obsAccel <= next_obsAccel;
			obsTimer <= next_obsTimer;
			speedFb <= next_speedFb;
		end
	end

	// speed loop
	srvsl_loop_state_type state;
	srvsl_loop_state_type next_state;
	logic [15:0] sampleTimer;
	logic [15:0] next_sampleTimer;
	srvsl_filt_state_type filtProp;
	srvsl_filt_state_type filtInt;
	srvsl_filt_state_type next_filtProp;
	srvsl_filt_state_type next_filtInt;
	logic signed [31:0] coefB;
	logic signed [31:0] coefA1;
	logic signed [31:0] coefA2;
	logic signed [31:0] next_coefB;
	logic signed [31:0] next_coefA1;
	logic signed [31:0] next_coefA2;
	logic signed [31:0] speedErr;
	logic signed [31:0] next_speedErr;
	logic signed [31:0] integ;
	logic signed [31:0] next_integ;
	logic signed [31:0] prefProp;
	logic signed [31:0] next_prefProp;
	logic signed [15:0] next_torque;
	logic signed [15:0] torqueCmd;
	logic signed [15:0] next_torqueCmd;
	logic next_saturated;
	srvsl_phase_refs_type next_phaseCurrentRefs;
	logic next_dacStrobe;
	logic signed [31:0] wT;
	logic signed [31:0] dampTerm;
	logic signed [47:0] piSum;
	logic signed [47:0] intStep;
	logic signed [31:0] propAct;
	logic signed [31:0] errP;
	logic signed [31:0] errI;
	logic signed [15:0] refU;
	logic signed [15:0] refV;

	always_comb begin
		next_state = state;
		next_sampleTimer = sampleTimer + 16'h0001;
		next_filtProp = filtProp;
		next_filtInt = filtInt;
		next_speedErr = speedErr;
		next_integ = integ;
		next_prefProp = prefProp;
		next_torque = torque;
		next_torqueCmd = torqueCmd;
		next_saturated = saturated;
		next_phaseCurrentRefs = phaseCurrentRefs;
		next_dacStrobe = 1'b0;
		// coefficients follow the setting; T is the loop period through the log form
		wT = lnInvQ16(filtSetting);
		dampTerm = 32'((64'(DAMP2_Q16) * 64'(wT)) >>> 16);
		next_coefB = 32'((64'(wT) * 64'(wT)) >>> 16);
		next_coefA1 = next_coefB - TWO_Q16 + dampTerm;
		next_coefA2 = ONE_Q16 - dampTerm;
		errP = filtProp.y1;
		errI = filtInt.y1;
		if (filtSetting == 8'h00) begin
			errP = speedErr;
			errI = speedErr;
		end
		propAct = 32'((64'($signed({1'b0, propGain})) * 64'(errP)) >>> KP_SHIFT);
		next_prefProp = prefProp + ((propAct - prefProp) >>> 2);
		intStep = 48'((64'($signed({1'b0, intGain})) * 64'(errI)) >>> KI_SHIFT);
		piSum = 48'(next_prefProp) + 48'(integ) + intStep;
		refU = 16'((32'(torqueCmd) * 32'(cosQ15(position))) >>> 15);
		refV = 16'((32'(torqueCmd) * 32'(cosQ15(position - PHASE_120))) >>> 15);
		case (state)
			ST_WAIT: begin
				if (sampleTimer >= 16'(SAMPLE_CYC - 1)) begin
					next_sampleTimer = 16'h0000;
					next_speedErr = 32'(speedRef) - 32'(speedFb);
					next_state = ST_FILT;
				end
			end
			ST_FILT: begin
				// two filter copies, both stepped every sample from speedErr with the same coefficients
				next_filtProp = filterStep(filtProp, speedErr, coefB, coefA1, coefA2);
				next_filtInt = filterStep(filtInt, speedErr, coefB, coefA1, coefA2);
				next_state = ST_PI;
			end
			ST_PI: begin
				next_torque = sat16(piSum);
				next_saturated = (piSum > 48'sh7fff) || (piSum < -48'sh8000);
				if (!next_saturated)
					next_integ = 32'(48'(integ) + intStep);
				next_torqueCmd = 16'(32'(torqueCmd) + ((32'(next_torque) - 32'(torqueCmd)) >>> 1));
				next_state = ST_ROT;
			end
			ST_ROT: begin
				next_phaseCurrentRefs.u = refU;
				next_phaseCurrentRefs.v = refV;
				next_phaseCurrentRefs.w = sat16(-(48'(refU) + 48'(refV)));
				next_dacStrobe = 1'b1;
				next_state = ST_WAIT;
			end
			default: next_state = ST_WAIT;
		endcase
		if (!ctrl[CTRL_RUN_BIT]) begin
			next_filtProp = '0;
			next_filtInt = '0;
			next_integ = 32'sh0;
			next_prefProp = 32'sh0;
			next_torque = 16'sh0;
			next_torqueCmd = 16'sh0;
			next_saturated = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= ST_WAIT;
			sampleTimer <= 16'h0;
			filtProp <= '0;
			filtInt <= '0;
			coefB <= 32'sh0;
			coefA1 <= 32'sh0;
			coefA2 <= 32'sh0;
			speedErr <= 32'sh0;
			integ <= 32'sh0;
			prefProp <= 32'sh0;
			torque <= 16'sh0;
			torqueCmd <= 16'sh0;
			saturated <= 1'b0;
			phaseCurrentRefs <= '0;
			dacStrobe <= 1'b0;
		end else begin
			state <= next_state;
			sampleTimer <= next_sampleTimer;
			filtProp <= next_filtProp;
			filtInt <= next_filtInt;
			coefB <= next_coefB;
			coefA1 <= next_coefA1;
			coefA2 <= next_coefA2;
			speedErr <= next_speedErr;
			integ <= next_integ;
			prefProp <= next_prefProp;
			torque <= next_torque;
			torqueCmd <= next_torqueCmd;
			saturated <= next_saturated;
			phaseCurrentRefs <= next_phaseCurrentRefs;
			dacStrobe <= next_dacStrobe;
		end
	end

	// pwm: symmetrical triangle 0..half, half selects 5 or 10 kHz
	logic [11:0] carrier;
	logic carrierUp;
	logic signed [15:0] modLim [3];
	logic [11:0] next_carrier;
	logic next_carrierUp;
	logic signed [15:0] next_modLim [3];
	logic [2:0] next_gateHigh;
	logic [2:0] next_gateLow;
	logic [11:0] half;
	logic [15:0] step;
	logic signed [15:0] modTarget [3];
	logic [27:0] level;

	always_comb begin
		half = ctrl[CTRL_FAST_BIT] ? CARRIER_HALF_FAST : CARRIER_HALF_BASE;
		step = ctrl[CTRL_FAST_BIT] ? SLOPE_FAST : SLOPE_BASE;
		next_carrierUp = carrierUp;
		if (carrierUp && carrier >= half - 12'h001)
			next_carrierUp = 1'b0;
		else if (!carrierUp && carrier <= 12'h001)
			next_carrierUp = 1'b1;
		if (carrier > half)
			next_carrier = half;
		else
			next_carrier = carrierUp ? carrier + 12'h001 : carrier - 12'h001;
		modTarget[0] = modU;
		modTarget[1] = modV;
		modTarget[2] = sat16(-(48'(modU) + 48'(modV)));
		next_gateHigh = 3'h0;
		for (int k = 0; k < 3; k++) begin
			// slope never steeper than the carrier, so one toggle per edge of the triangle
			next_modLim[k] = slopeLimit(modLim[k], modTarget[k], step);
			level = 28'({~modLim[k][15], modLim[k][14:0]}) * 28'(half);
			next_gateHigh[k] = (level[27:16] > carrier);
		end
		next_gateLow = ~next_gateHigh;
		if (!ctrl[CTRL_RUN_BIT]) begin
			next_gateHigh = 3'h0;
			next_gateLow = 3'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			carrier <= 12'h0;
			carrierUp <= 1'b1;
			for (int k = 0; k < 3; k++)
				modLim[k] <= 16'sh0;
			gateHigh <= 3'h0;
			gateLow <= 3'h0;
		end else begin
			carrier <= next_carrier;
			carrierUp <= next_carrierUp;
			for (int k = 0; k < 3; k++)
				modLim[k] <= next_modLim[k];
			gateHigh <= next_gateHigh;
			gateLow <= next_gateLow;
		end
	end
endmodule : srvsl_speed_loop

// ==== verification/srvsl_speed_loop_sva.sv ====
/*
 * Port checker of the servo speed loop: apb timing, dac strobe spacing, gate and phase relations.
 * Assumes it is bound onto srvsl_speed_loop, one clock, synchronous active-high reset.
 */
`timescale 1ns/100ps
module srvsl_speed_loop_sva
	import srvsl_pkg::*;
#(
	parameter int SAMPLE_CYC = SAMPLE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// dac and gates
	input wire srvsl_phase_refs_type phaseCurrentRefs,
	input wire logic dacStrobe,
	input wire logic [2:0] gateHigh,
	input wire logic [2:0] gateLow
);
	int gap;
	int next_gap;
	logic seen;
	logic next_seen;
	logic badAddr;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// a strobe comes every sample, run or not; the check still allows any whole sample multiple
	always_comb begin
		next_gap = dacStrobe ? 1 : gap + 1;
		next_seen = seen | dacStrobe;
		badAddr = (paddr > 12'h020) || (paddr[1:0] != 2'h0);
	end
	always_ff @(posedge clk) begin
		gap <= srst ? 0 : next_gap;
		seen <= srst ? 1'b0 : next_seen;
	end
	a_apb_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("apb answer not in second access cycle");
	a_pready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_slverr_decode: assert property (pready |-> pslverr == badAddr)
		else $error("pslverr disagrees with address decode");
	a_slverr_nodata: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused access returned data");
	a_strobe_spacing: assert property (dacStrobe && seen |-> gap % SAMPLE_CYC == 0)
		else $error("dac strobe off the sample grid");
	a_strobe_pulse: assert property (dacStrobe |=> !dacStrobe)
		else $error("dac strobe longer than one cycle");
	a_refs_strobed: assert property (!$stable(phaseCurrentRefs) |-> dacStrobe)
		else $error("refs changed without strobe");
	a_phase_sum: assert property (dacStrobe |-> 16'(phaseCurrentRefs.u + phaseCurrentRefs.v + phaseCurrentRefs.w) == 16'h0)
		else $error("phase refs do not sum to zero");
	a_gate_pair: assert property ((gateHigh | gateLow) != 3'h0 |-> gateLow == ~gateHigh)
		else $error("gate pair not complementary");
	c_strobe_live: cover property (dacStrobe && phaseCurrentRefs.u != 16'h0);
	c_refused: cover property (pready && pslverr);
	c_gate_rise: cover property ($rose(gateHigh[0]));
endmodule : srvsl_speed_loop_sva

bind srvsl_speed_loop srvsl_speed_loop_sva #(.SAMPLE_CYC(SAMPLE_CYC)) u_srvsl_speed_loop_sva (.clk(clk), .srst(srst),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.phaseCurrentRefs(phaseCurrentRefs), .dacStrobe(dacStrobe), .gateHigh(gateHigh), .gateLow(gateLow));

// ==== verification/srvsl_drive_model.sv ====
/*
 * Far side of the speed loop: resolver converter word, two modulating words and the phase dac.
 * Assumes the bench clock; pin words change just after a rising edge like real async sources.
 */
`timescale 1ns/100ps
module srvsl_drive_model
	import srvsl_pkg::*;
(
	// clock and bench settings
	input wire logic clk,
	input wire logic [15:0] rate,
	input wire logic signed [15:0] modU,
	input wire logic signed [15:0] modV,
	// pins toward the loop
	output logic [15:0] shaftPosition,
	output logic signed [15:0] modulationU,
	output logic signed [15:0] modulationV,
	// dac side
	input wire srvsl_phase_refs_type phaseCurrentRefs,
	input wire logic dacStrobe,
	output srvsl_phase_refs_type dacHeld,
	output int dacCount
);
	initial begin
		shaftPosition = 16'h0000;
		modulationU = 16'sh0000;
		modulationV = 16'sh0000;
		dacHeld = '0;
		dacCount = 0;
	end
	always @(posedge clk) begin
		shaftPosition <= shaftPosition + rate;
		// only two words exist; the loop must rebuild the third
		modulationU <= modU;
		modulationV <= modV;
		if (dacStrobe) begin
			dacHeld <= phaseCurrentRefs;
			dacCount <= dacCount + 1;
		end
	end
endmodule : srvsl_drive_model

// ==== verification/tb.sv ====
/*
 * Self-checking bench of the servo speed loop over apb, with the drive model on the far side.
 * Assumes shortened sample and observer counts; apb answers with one wait state.
 */
`timescale 1ns/100ps
module tb
	import srvsl_pkg::*;
;
	localparam int SC = 40;
	logic clk, srst, psel, penable, pwrite, pready, pslverr, dacStrobe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] rate, shaftPosition;
	logic signed [15:0] modU, modV, modulationU, modulationV;
	logic [2:0] gateHigh, gateLow;
	srvsl_phase_refs_type phaseCurrentRefs, dacHeld;
	int dacCount, errTotal, nTests, k, i, hiU, hiW, rise;
	logic last;
	int pU[3] = '{0, 16384, 16384};
	// nonzero v in the last pass, so the rebuilt w must depend on both words
	int pV[3] = '{0, 0, -8192};
	int xU[3] = '{2000, 3000, 1500};
	int xW[3] = '{2000, 1000, 750};
	int pPer[3] = '{4000, 4000, 2000};
	int fIn[4] = '{150, 100, 1, 0};
	int fOut[4] = '{100, 100, 1, 0};

	srvsl_speed_loop #(.SAMPLE_CYC(SC), .OBS_CYC(20)) u_srvsl_speed_loop (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shaftPosition(shaftPosition), .modulationU(modulationU), .modulationV(modulationV),
		.phaseCurrentRefs(phaseCurrentRefs), .dacStrobe(dacStrobe), .gateHigh(gateHigh), .gateLow(gateLow));
	srvsl_drive_model u_srvsl_drive_model (.clk(clk), .rate(rate), .modU(modU), .modV(modV),
		.shaftPosition(shaftPosition), .modulationU(modulationU), .modulationV(modulationV),
		.phaseCurrentRefs(phaseCurrentRefs), .dacStrobe(dacStrobe), .dacHeld(dacHeld), .dacCount(dacCount));

	always #25 clk = ~clk;

	task automatic giveVerdict;
		$display("comparisons %0d mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : giveVerdict

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		nTests++;
		if (seen !== exp) begin
			errTotal++;
			$display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// an edge always passes first, so back-to-back calls never drive a signal twice at once
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errTotal++;
			giveVerdict();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic e;
		apb(1'b1, a, d, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic e;
		apb(1'b0, a, 32'h0, e);
		check(q, x);
		check(e, xe);
	endtask : rd

	// polls until the value shows, bounded by the read count
	task automatic waitReg(input logic [11:0] a, input logic [31:0] x);
		logic e;
		for (int n = 0; n < 300; n++) begin
			apb(1'b0, a, 32'h0, e);
			if (q === x) break;
		end
		check(q, x);
	endtask : waitReg

	initial begin
		clk = 1'b0;
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rate = 16'h0000;
		modU = 16'sh0000;
		modV = 16'sh0000;
		errTotal = 0;
		nTests = 0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		rd(REG_CTRL, 32'h0, 1'b0);
		rd(REG_PROP_GAIN, 32'h50, 1'b0);
		rd(REG_INT_GAIN, 32'h14, 1'b0);
		rd(REG_STATUS, 32'h2, 1'b0);
		rd(12'h024, 32'h0, 1'b1);
		rd(12'h002, 32'h0, 1'b1);
		wr(REG_SPEED_FB, 32'h1234);
		rd(REG_SPEED_FB, 32'h0, 1'b0);
		for (k = 0; k < 4; k++) begin
			wr(REG_FILT_FREQ, fIn[k]);
			rd(REG_FILT_FREQ, fOut[k], 1'b0);
		end
		rd(REG_STATUS, 32'h2, 1'b0);
		rate <= 16'h1234;
		@(posedge clk);
		rate <= 16'h0000;
		repeat (6) @(posedge clk);
		rd(REG_POSITION, 32'h1234, 1'b0);
		wr(REG_SPEED_REF, 32'h7fff);
		wr(REG_CTRL, 32'h1);
		waitReg(REG_TORQUE, 32'h7fff);
		rd(REG_STATUS, 32'h7, 1'b0);
		repeat (6 * SC) @(posedge clk);
		check({dacHeld.u[15], dacHeld.w[15]}, 2'b01);
		wr(REG_SPEED_REF, 32'h8000);
		waitReg(REG_TORQUE, 32'hffff8000);
		repeat (6 * SC) @(posedge clk);
		check({dacHeld.u[15], dacHeld.w[15]}, 2'b10);
		wr(REG_CTRL, 32'h0);
		i = dacCount;
		repeat (3 * SC) @(posedge clk);
		check(dacCount - i, 3);
		check(dacHeld, 48'h0);
		check({gateHigh, gateLow}, 6'h0);
		wr(REG_SPEED_REF, 32'h0);
		for (k = 0; k < 3; k++) begin
			wr(REG_CTRL, (k == 2) ? 32'h3 : 32'h1);
			modU <= 16'(pU[k]);
			modV <= 16'(pV[k]);
			repeat (1200) @(posedge clk);
			hiU = 0;
			hiW = 0;
			rise = 0;
			last = gateHigh[0];
			for (i = 0; i < pPer[k]; i++) begin
				@(posedge clk);
				hiU += gateHigh[0];
				hiW += gateHigh[2];
				rise += (gateHigh[0] && !last);
				last = gateHigh[0];
			end
			check(hiU inside {[xU[k] - 4:xU[k] + 4]}, 1'b1);
			check(hiW inside {[xW[k] - 4:xW[k] + 4]}, 1'b1);
			check(rise, 1);
		end
		giveVerdict();
	end
endmodule : tb
